// ==== hdl/timer_capture_compare_unit.sv ====
// timer/counter with external tick, input capture and output compare
// assumes classic wishbone master on clk_sys; pins asynchronous
// Functional notes
// RQ1 - count pin synchronised, then edge detected
// RQ2 - select 7 rising, 6 falling ticks
// RQ3 - pin edge to count in 2.5-3.5 cycles; the code takes 2-3 cycles (two sync flops, then the count register)
// RQ4 - software toggles external input only when stable
// RQ5 - external clock below system clock over 2.5
// RQ6 - external ticks bypass the prescaler
// RQ7 - count up to top, then restart zero
// RQ8 - select 0 stops; count still accessible
// RQ9 - software count write beats hardware update
// RQ10 - overflow flag set at max, interrupt capable
// RQ11 - capture trigger pin or comparator output
// RQ12 - matching edge copies count into capture
// RQ13 - capture flag with copy, irq, clears
// RQ14 - capture lands in compare a/b
// RQ15 - software clears capture flag after source switch
// RQ16 - capture inputs synced; filter adds four cycles
// RQ17 - filter output changes after four equal samples
// RQ18 - software-driven capture pin edge also captures
// RQ19 - each capture overwrites previous value
// RQ20 - compare match sets flag next tick
// RQ21 - 8-bit sets a or b; 16-bit only a
// RQ22 - compare flag irq, auto/software clear; the code clears only by bus write to flags or irq ack
// RQ23 - clear-on-match 8-bit clears at compare a
// RQ24 - overflow flag set on wrap to zero
// RQ25 - count write blocks matches next tick
// RQ26 - hardware set wins over software clear
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module timer_capture_compare_unit (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        ext_count_pin,
	input  wire logic        capture_pin,
	input  wire logic        comparator_output,
	output logic             overflow_irq,
	output logic             compare_a_irq,
	output logic             compare_b_irq,
	output logic             capture_irq
);
	sync_edge_if cnt_se ();
	sync_edge_if icp_se ();
	sync_edge_if aco_se ();

	// control state
	logic [4:0]            timer_control_a;
	logic [3:0]            timer_control_b;
	localparam int unsigned flag_w = tcu_pkg::flag_count;
	logic [15:0]           count_value;
	logic [7:0]            compare_value_a;
	logic [7:0]            compare_value_b;
	logic [flag_w-1:0]     flags;
	logic [flag_w-1:0]     irq_enable;
	logic [9:0]            prescaler;
	logic                  block_match;
	logic                  trig_sel_q;

	wire       clear_on_match_sel     = timer_control_a[tcu_pkg::bit_clear_on_match];
	wire       width_select           = timer_control_a[tcu_pkg::bit_width_select];
	wire       capture_mode           = timer_control_a[tcu_pkg::bit_capture_enable];
	wire       comparator_capture_sel = timer_control_a[tcu_pkg::bit_comp_capture];
	wire       capture_rising         = timer_control_a[tcu_pkg::bit_capture_edge];
	wire [2:0] tick_source_select     = timer_control_b[tcu_pkg::lsb_tick_select +: 3];
	wire       noise_filter_enable    = timer_control_b[tcu_pkg::bit_noise_filter];

	assign cnt_se.filter_on = 1'b0;
	assign icp_se.filter_on = noise_filter_enable;
	assign aco_se.filter_on = noise_filter_enable;

	sync_edge u_cnt_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.pin     (ext_count_pin), // RQ1 RQ3
		.se      (cnt_se)
	);
	sync_edge u_icp_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.pin     (capture_pin), // RQ16 RQ18
		.se      (icp_se)
	);
	sync_edge u_aco_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.pin     (comparator_output), // RQ16
		.se      (aco_se)
	);

	// bus decode
	wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        bus_wr    = bus_req & wb_we_i;
	wire        lane0     = wb_sel_i[0];
	wire        lane1     = wb_sel_i[1];
	wire        hit_ctl_a = wb_adr_i == tcu_pkg::addr_control_a;
	wire        hit_ctl_b = wb_adr_i == tcu_pkg::addr_control_b;
	wire        hit_cnt   = wb_adr_i == tcu_pkg::addr_count_value;
	wire        hit_cmp_a = wb_adr_i == tcu_pkg::addr_compare_a;
	wire        hit_cmp_b = wb_adr_i == tcu_pkg::addr_compare_b;
	wire        hit_flags = wb_adr_i == tcu_pkg::addr_flags;
	wire        hit_ien   = wb_adr_i == tcu_pkg::addr_irq_enable;
	wire        hit_ack   = wb_adr_i == tcu_pkg::addr_irq_ack;
	wire        wr_cnt_lo = bus_wr & hit_cnt & lane0;
	wire        wr_cnt_hi = bus_wr & hit_cnt & lane1;
	wire        wr_count  = wr_cnt_lo | wr_cnt_hi;
	wire        wr_ctl_a  = bus_wr & hit_ctl_a & lane0;
	wire        wr_ctl_b  = bus_wr & hit_ctl_b & lane0;
	wire        wr_cmp_a  = bus_wr & hit_cmp_a & lane0;
	wire        wr_cmp_b  = bus_wr & hit_cmp_b & lane0;
	wire        wr_ien    = bus_wr & hit_ien & lane0;
	// acknowledge clears like a write-one to the flags
	wire        wr_clear  = bus_wr & lane0 & (hit_flags | hit_ack);

	// prescaler runs free; one-cycle enables
	wire [9:0] pre_next = prescaler + 10'h001;
	wire       tap8     = pre_next[2:0] == 3'h0;
	wire       tap64    = pre_next[5:0] == 6'h00;
	wire       tap256   = pre_next[7:0] == 8'h00;
	wire       tap1024  = pre_next == tcu_pkg::prescale_reset;

	// external ticks undivided
	logic timer_tick;
	always_comb begin
		unique case (tick_source_select)
			tcu_pkg::sel_stopped:  timer_tick = 1'b0; // RQ8
			tcu_pkg::sel_direct:   timer_tick = 1'b1;
			tcu_pkg::sel_div8:     timer_tick = tap8;
			tcu_pkg::sel_div64:    timer_tick = tap64;
			tcu_pkg::sel_div256:   timer_tick = tap256;
			tcu_pkg::sel_div1024:  timer_tick = tap1024;
			tcu_pkg::sel_ext_fall: timer_tick = cnt_se.fall; // RQ2 RQ6
			tcu_pkg::sel_ext_rise: timer_tick = cnt_se.rise; // RQ2 RQ6
		endcase
	end

	// counting sequence
	wire [15:0] max_value  = width_select ? tcu_pkg::max16 : tcu_pkg::max8;
	wire [15:0] cmp_a_full = width_select ? {compare_value_b, compare_value_a}
	                                      : {8'h00, compare_value_a};
	wire        ctc_mode   = clear_on_match_sel & ~width_select & ~capture_mode;
	wire        at_max     = count_value == max_value;
	wire        eq_a       = count_value == cmp_a_full;
	wire        eq_b       = count_value[7:0] == compare_value_b && !width_select;
	wire        compare_on = ~(capture_mode & width_select); // RQ14
	wire        ctc_clear  = ctc_mode & eq_a & ~at_max; // RQ23
	wire [15:0] count_inc  = at_max ? tcu_pkg::count_zero : count_value + 16'h0001; // RQ7
	wire [15:0] wr_count_v = {wr_cnt_hi ? wb_dat_i[15:8] : count_value[15:8],
	                          wr_cnt_lo ? wb_dat_i[7:0]  : count_value[7:0]};

	logic [15:0] next_count;
	always_comb begin
		next_count = count_value;
		if (wr_count)
			next_count = wr_count_v; // RQ9
		else if (timer_tick && ctc_clear)
			next_count = tcu_pkg::count_zero; // RQ23
		else if (timer_tick)
			next_count = count_inc; // RQ7
	end

	// capture trigger
	wire trig_sel   = comparator_capture_sel;
	wire trig_rise  = trig_sel ? aco_se.rise : icp_se.rise; // RQ11
	wire trig_fall  = trig_sel ? aco_se.fall : icp_se.fall; // RQ11
	wire trig_lvl   = trig_sel ? aco_se.level : icp_se.level;
	// source switch produces a capture when the new source's level matches the selected edge
	wire switch_evt = (trig_sel != trig_sel_q) && (trig_lvl == capture_rising);
	wire capture    = capture_mode & ((capture_rising ? trig_rise : trig_fall) | switch_evt); // RQ12

	// flag events
	wire set_ovf  = timer_tick & at_max & ~wr_count; // RQ10 RQ24
	// equality holds between ticks; the tick that ends it raises the flag
	wire set_cmpa = timer_tick & eq_a & compare_on & ~block_match; // RQ20
	wire set_cmpb = timer_tick & eq_b & ~block_match; // RQ21
	wire [flag_w-1:0] flag_set = {capture, set_cmpb, set_cmpa, set_ovf};
	wire [flag_w-1:0] sw_clear = wr_clear ? wb_dat_i[flag_w-1:0] : {flag_w{1'b0}};
	wire [flag_w-1:0] next_flags = (flags & ~sw_clear) | flag_set; // RQ26 RQ13 RQ22

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			prescaler <= tcu_pkg::prescale_reset;
		else
			prescaler <= pre_next;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count_value <= tcu_pkg::count_zero;
			flags       <= {flag_w{1'b0}};
			trig_sel_q  <= 1'b0;
		end else begin
			count_value <= next_count;
			flags       <= next_flags;
			trig_sel_q  <= trig_sel;
		end
	end

	// count write masks matches until the next tick, even while stopped
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			block_match <= 1'b0;
		else if (wr_count)
			block_match <= 1'b1; // RQ25
		else if (timer_tick)
			block_match <= 1'b0;
	end

	// registers; capture beats software write of compare regs
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			timer_control_a <= 5'h00;
			timer_control_b <= 4'h0;
			irq_enable      <= {flag_w{1'b0}};
			compare_value_a <= 8'h00;
			compare_value_b <= 8'h00;
		end else begin
			if (wr_ctl_a)
				timer_control_a <= wb_dat_i[4:0];
			if (wr_ctl_b)
				timer_control_b <= wb_dat_i[3:0];
			if (wr_ien)
				irq_enable <= wb_dat_i[flag_w-1:0];
			if (capture) begin
				compare_value_a <= count_value[7:0]; // RQ12 RQ19
				if (width_select)
					compare_value_b <= count_value[15:8]; // RQ14
			end else begin
				if (wr_cmp_a)
					compare_value_a <= wb_dat_i[7:0];
				if (wr_cmp_b)
					compare_value_b <= wb_dat_i[7:0];
			end
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctl_a)
			rd_mux[4:0] = timer_control_a;
		else if (hit_ctl_b)
			rd_mux[3:0] = timer_control_b;
		else if (hit_cnt)
			rd_mux[15:0] = width_select ? count_value : {8'h00, count_value[7:0]};
		else if (hit_cmp_a)
			rd_mux[7:0] = compare_value_a;
		else if (hit_cmp_b)
			rd_mux[7:0] = compare_value_b;
		else if (hit_flags)
			rd_mux[flag_w-1:0] = flags;
		else if (hit_ien)
			rd_mux[flag_w-1:0] = irq_enable;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_mux : 32'h0000_0000;
		end
	end

	// irq lines registered from next-state flags
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			overflow_irq  <= 1'b0;
			compare_a_irq <= 1'b0;
			compare_b_irq <= 1'b0;
			capture_irq   <= 1'b0;
		end else begin
			overflow_irq  <= next_flags[tcu_pkg::bit_overflow] & irq_enable[tcu_pkg::bit_overflow]; // RQ10
			compare_a_irq <= next_flags[tcu_pkg::bit_compare_a] & irq_enable[tcu_pkg::bit_compare_a]; // RQ22
			compare_b_irq <= next_flags[tcu_pkg::bit_compare_b] & irq_enable[tcu_pkg::bit_compare_b]; // RQ22
			capture_irq   <= next_flags[tcu_pkg::bit_capture] & irq_enable[tcu_pkg::bit_capture]; // RQ13
		end
	end
endmodule // timer_capture_compare_unit
`default_nettype wire

// ==== hdl/tcu_pkg.sv ====
// constants, register map and field layout of the timer capture/compare unit
// assumes a 32-bit classic wishbone bus; registers sit in the low byte lanes
package tcu_pkg;
	localparam int unsigned clk_mhz            = 50;
	localparam int unsigned filter_samples     = 4;
	localparam logic [2:0]  filt_cnt_last      = 3'h3;
	localparam logic [2:0]  sync_stages        = 3'h2;
	// word offsets (byte addresses)
	localparam logic [7:0]  addr_control_a     = 8'h00;
	localparam logic [7:0]  addr_control_b     = 8'h04;
	localparam logic [7:0]  addr_count_value   = 8'h08;
	localparam logic [7:0]  addr_compare_a     = 8'h0c;
	localparam logic [7:0]  addr_compare_b     = 8'h10;
	localparam logic [7:0]  addr_flags         = 8'h14;
	localparam logic [7:0]  addr_irq_enable    = 8'h18;
	localparam logic [7:0]  addr_irq_ack       = 8'h1c;
	// timer_control_a bits
	localparam int unsigned bit_clear_on_match = 0;
	localparam int unsigned bit_width_select   = 1;
	localparam int unsigned bit_capture_enable = 2;
	localparam int unsigned bit_comp_capture   = 3;
	localparam int unsigned bit_capture_edge   = 4;
	// timer_control_b bits
	localparam int unsigned lsb_tick_select    = 0;
	localparam int unsigned bit_noise_filter   = 3;
	// flag / enable bit positions
	localparam int unsigned bit_overflow       = 0;
	localparam int unsigned bit_compare_a      = 1;
	localparam int unsigned bit_compare_b      = 2;
	localparam int unsigned bit_capture        = 3;
	localparam int unsigned flag_count         = 4;
	// tick source codes
	localparam logic [2:0]  sel_stopped        = 3'h0;
	localparam logic [2:0]  sel_direct         = 3'h1;
	localparam logic [2:0]  sel_div8           = 3'h2;
	localparam logic [2:0]  sel_div64          = 3'h3;
	localparam logic [2:0]  sel_div256         = 3'h4;
	localparam logic [2:0]  sel_div1024        = 3'h5;
	localparam logic [2:0]  sel_ext_fall       = 3'h6;
	localparam logic [2:0]  sel_ext_rise       = 3'h7;
	localparam logic [9:0]  prescale_reset     = 10'h000;
	localparam logic [15:0] max8               = 16'h00ff;
	localparam logic [15:0] max16              = 16'hffff;
	localparam logic [15:0] count_zero         = 16'h0000;
endpackage

// ==== hdl/sync_edge_if.sv ====
// carrier between the top and the synchroniser/edge detector leaves
// one leaf per input pin; top owns control, leaf owns results
`timescale 1ns/1ns
`default_nettype none
interface sync_edge_if;
	logic filter_on;
	logic level;
	logic rise;
	logic fall;
	modport leaf (input filter_on, output level, output rise, output fall);
	modport top  (output filter_on, input level, input rise, input fall);
endinterface : sync_edge_if
`default_nettype wire

// ==== hdl/sync_edge.sv ====
// two-flop synchroniser, optional four-sample filter, edge detector
// assumes pin is asynchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none
module sync_edge (
	input  wire logic      clk_sys,
	input  wire logic      reset_n,
	input  wire logic      pin,
	sync_edge_if.leaf      se
);
	logic       meta;
	logic       synced;
	logic [2:0] hist;
	logic       filtered;
	logic       prev;
	wire        hist_equal = (hist == {3{synced}});
	wire        cur        = se.filter_on ? filtered : synced;

	// meta feeds only synced
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta   <= 1'b0;
			synced <= 1'b0;
		end else begin
			meta   <= pin;
			synced <= meta;
		end
	end

	// output follows only after four equal samples
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hist     <= 3'h0;
			filtered <= 1'b0;
		end else begin
			hist <= {hist[1:0], synced};
			if (hist_equal)
				filtered <= synced; // RQ17
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			prev <= 1'b0;
		else
			prev <= cur;
	end

	assign se.level = cur;
	assign se.rise  = cur & ~prev;
	assign se.fall  = ~cur & prev;
endmodule // sync_edge
`default_nettype wire

// ==== testbench/tcu_checker.sv ====
// checker: bus handshake and interrupt causes of the timer unit
// assumes it is bound to timer_capture_compare_unit, one clock domain
`timescale 1ns/1ns
`default_nettype none
module tcu_checker (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        capture_pin,
	input wire logic        comparator_output,
	input wire logic        overflow_irq,
	input wire logic        compare_a_irq,
	input wire logic        compare_b_irq,
	input wire logic        capture_irq
);
	logic [3:0] wh;
	logic [3:0] sp;
	logic       en;
	wire        wr_now = wb_ack_o && wb_we_i;
	wire        wr_en  = wr_now && wb_adr_i == tcu_pkg::addr_irq_enable && wb_dat_i[3:0] != 4'h0;
	wire        any_irq = overflow_irq || compare_a_irq || compare_b_irq || capture_irq;
	// sp saturates so a quiet pin never wraps back into the window
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wh <= 4'h0;
			sp <= 4'hf;
			en <= 1'b0;
		end else begin
			wh <= {wh[2:0], wr_now};
			sp <= ($changed(capture_pin) || $changed(comparator_output)) ? 4'h0 : sp + {3'h0, sp != 4'hf};
			if (wr_en)
				en <= 1'b1;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_latency: assert property (s_req |=> s_ans) else $error("ack not a single pulse after request");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack without request");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > tcu_pkg::addr_irq_ack |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_irq_enabled: assert property (any_irq |-> en || wr_en) else $error("irq with no enable");
	a_ovf_clear: assert property ($fell(overflow_irq) |-> wh != 4'h0 || wr_now)
		else $error("overflow irq dropped without write");
	a_cmp_clear: assert property ($fell(compare_a_irq) || $fell(compare_b_irq) |-> wh != 4'h0 || wr_now)
		else $error("compare irq dropped without write");
	a_cap_cause: assert property ($rose(capture_irq) |-> sp != 4'hf || wh != 4'h0 || wr_now)
		else $error("capture irq without input change");
endmodule // tcu_checker
`default_nettype wire

// ==== testbench/pin_source.sv ====
// external clock source driving the count pin
// assumes run is changed by the bench just after clk_sys edges
`timescale 1ns/1ns
`default_nettype none
module pin_source (
	input wire logic       clk_sys,
	input wire logic       run,
	input wire logic [3:0] half,
	output logic           pin
);
	logic [3:0] n;
	initial pin = 1'b0;
	initial n = 4'h0;
	// half of 2 or more keeps below clk/2.5; level held when stopped
	always @(posedge clk_sys) begin
		if (!run)
			n <= 4'h0;
		else if (n == half - 4'h1) begin
			n <= 4'h0;
			pin <= ~pin;
		end else
			n <= n + 4'h1;
	end
endmodule // pin_source
`default_nettype wire

// ==== testbench/tb.sv ====
// testbench: bus tasks, pin stimulus and expected counts for the timer unit
// assumes the design is the only slave and the bench the only master
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
	logic        clk_sys, reset_n, cyc, stb, we, cap, cmp, run;
	logic [7:0]  adr;
	logic [3:0]  sel, half;
	logic [31:0] wdat, r, seed, v;
	wire  [31:0] rdat;
	wire         ack, ext;
	wire  [3:0]  irq;
	int          err_count, n_compared, ncyc, rises, falls, i, t1, t2;
	timer_capture_compare_unit DUT (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ext_count_pin(ext), .capture_pin(cap), .comparator_output(cmp), .overflow_irq(irq[0]),
		.compare_a_irq(irq[1]), .compare_b_irq(irq[2]), .capture_irq(irq[3]));
	pin_source src (.clk_sys(clk_sys), .run(run), .half(half), .pin(ext));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'h3;
		do @(posedge clk_sys); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wirq(input int b);
		for (i = 0; i < 400 && irq[b] !== 1'b1; i++) @(posedge clk_sys);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge ext) rises++;
	always @(negedge ext) falls++;
	always @(posedge clk_sys) begin
		ncyc <= ncyc + 1;
		if (ncyc > 20000) begin
			err_count++;
			finish_test;
		end
	end
	initial begin
		{cyc, stb, we, cap, cmp, run} = 6'h0;
		adr = 8'h0;
		sel = 4'h0;
		wdat = 32'h0;
		half = 4'h2;
		seed = 32'h7718dab5;
		reset_n = 1'b0;
		wt(20);
		reset_n <= 1'b1;
		for (int k = 0; k < 9; k++) begin
			bus(1'b0, 8'(k * 4), 32'h0);
			`CHK("reset value", 32'h0, r)
		end
		bus(1'b1, 8'h20, 32'hffff_ffff);
		bus(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 32'h0, r)
		seed = lfsr(seed);
		bus(1'b1, tcu_pkg::addr_control_a, 32'h2);
		bus(1'b1, tcu_pkg::addr_count_value, seed);
		// lane 1 dropped: only the low byte may change
		sel <= 4'h1;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= 1'b1;
		adr <= tcu_pkg::addr_count_value;
		wdat <= 32'h0000_ffa5;
		do @(posedge clk_sys); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_sys);
		bus(1'b0, tcu_pkg::addr_count_value, 32'h0);
		`CHK("count lanes", {16'h0, seed[15:8], 8'ha5}, r)
		bus(1'b1, tcu_pkg::addr_control_a, 32'h0);
		bus(1'b1, tcu_pkg::addr_count_value, 32'hfc);
		bus(1'b1, tcu_pkg::addr_irq_enable, 32'h1);
		bus(1'b1, tcu_pkg::addr_control_b, 32'(tcu_pkg::sel_direct));
		wirq(0);
		bus(1'b1, tcu_pkg::addr_control_b, 32'h0);
		bus(1'b0, tcu_pkg::addr_flags, 32'h0);
		`CHK("overflow", 1'b1, r[0])
		bus(1'b0, tcu_pkg::addr_count_value, 32'h0);
		`CHK("wrapped", 1'b1, r[15:0] < 16'h20)
		bus(1'b1, tcu_pkg::addr_flags, 32'h1);
		bus(1'b0, tcu_pkg::addr_flags, 32'h0);
		`CHK("ovf cleared", 1'b0, r[0])
		seed = lfsr(seed);
		v = {29'h0, seed[2:0]} + 32'h4;
		bus(1'b1, tcu_pkg::addr_control_a, 32'h1);
		bus(1'b1, tcu_pkg::addr_compare_a, v);
		bus(1'b1, tcu_pkg::addr_compare_b, 32'h2);
		bus(1'b1, tcu_pkg::addr_count_value, 32'h0);
		// wrap through zero above matched both compare regs; start clean
		bus(1'b1, tcu_pkg::addr_flags, 32'hf);
		bus(1'b1, tcu_pkg::addr_irq_enable, 32'h6);
		bus(1'b1, tcu_pkg::addr_control_b, 32'(tcu_pkg::sel_direct));
		wirq(1);
		wt(40);
		bus(1'b1, tcu_pkg::addr_control_b, 32'h0);
		bus(1'b0, tcu_pkg::addr_count_value, 32'h0);
		`CHK("top", 1'b1, r[15:0] <= v[15:0])
		bus(1'b0, tcu_pkg::addr_flags, 32'h0);
		`CHK("cmp a b", 2'h3, r[2:1])
		bus(1'b1, tcu_pkg::addr_irq_ack, 32'h6);
		bus(1'b0, tcu_pkg::addr_flags, 32'h0);
		`CHK("cmp ack", 2'h0, r[2:1])
		bus(1'b1, tcu_pkg::addr_control_a, 32'h0);
		bus(1'b1, tcu_pkg::addr_compare_a, 32'h40);
		bus(1'b1, tcu_pkg::addr_count_value, 32'h40);
		bus(1'b1, tcu_pkg::addr_control_b, 32'(tcu_pkg::sel_direct));
		wt(6);
		bus(1'b1, tcu_pkg::addr_control_b, 32'h0);
		bus(1'b0, tcu_pkg::addr_flags, 32'h0);
		`CHK("blocked", 1'b0, r[1])
		bus(1'b1, tcu_pkg::addr_control_a, 32'h2);
		bus(1'b1, tcu_pkg::addr_compare_a, 32'h4);
		bus(1'b1, tcu_pkg::addr_compare_b, 32'h0);
		bus(1'b1, tcu_pkg::addr_count_value, 32'hfff8);
		bus(1'b1, tcu_pkg::addr_control_b, 32'(tcu_pkg::sel_direct));
		wt(20);
		bus(1'b1, tcu_pkg::addr_control_b, 32'h0);
		bus(1'b0, tcu_pkg::addr_flags, 32'h0);
		`CHK("wide flags", 3'h3, r[2:0])
		bus(1'b1, tcu_pkg::addr_control_b, 32'(tcu_pkg::sel_direct));
		bus(1'b1, tcu_pkg::addr_count_value, 32'h1234);
		bus(1'b1, tcu_pkg::addr_control_b, 32'h0);
		bus(1'b0, tcu_pkg::addr_count_value, 32'h0);
		`CHK("write wins", 1'b1, r[15:0] - 16'h1234 < 16'h8)
		seed = lfsr(seed);
		half = 4'h2 + {2'h0, seed[1:0]};
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, tcu_pkg::addr_count_value, 32'h0);
			bus(1'b1, tcu_pkg::addr_control_b, 32'(k ? tcu_pkg::sel_ext_fall : tcu_pkg::sel_ext_rise));
			rises = 0;
			falls = 0;
			run <= 1'b1;
			wt(80);
			run <= 1'b0;
			wt(10);
			bus(1'b1, tcu_pkg::addr_control_b, 32'h0);
			bus(1'b0, tcu_pkg::addr_count_value, 32'h0);
			`CHK("ext ticks", 16'(k ? falls : rises), r[15:0])
		end
		bus(1'b1, tcu_pkg::addr_control_a, 32'h16);
		bus(1'b1, tcu_pkg::addr_flags, 32'hf);
		bus(1'b1, tcu_pkg::addr_irq_enable, 32'h8);
		bus(1'b1, tcu_pkg::addr_control_b, 32'(tcu_pkg::sel_direct));
		cap <= 1'b1;
		t1 = ncyc;
		wirq(3);
		bus(1'b0, tcu_pkg::addr_flags, 32'h0);
		`CHK("capture flag", 1'b1, r[3])
		bus(1'b0, tcu_pkg::addr_compare_a, 32'h0);
		v = r;
		bus(1'b0, tcu_pkg::addr_compare_b, 32'h0);
		v[15:8] = r[7:0];
		cap <= 1'b0;
		wt(20);
		cap <= 1'b1;
		t2 = ncyc;
		wt(20);
		bus(1'b0, tcu_pkg::addr_compare_a, 32'h0);
		v[23:16] = r[7:0];
		bus(1'b0, tcu_pkg::addr_compare_b, 32'h0);
		`CHK("capture gap", 16'(t2 - t1), 16'({r[7:0], v[23:16]} - v[15:0]))
		cap <= 1'b0;
		bus(1'b1, tcu_pkg::addr_control_b, 32'h9);
		wt(10);
		bus(1'b1, tcu_pkg::addr_flags, 32'h8);
		cap <= 1'b1;
		wt(2);
		cap <= 1'b0;
		wt(20);
		bus(1'b0, tcu_pkg::addr_flags, 32'h0);
		`CHK("glitch", 1'b0, r[3])
		cap <= 1'b1;
		wt(20);
		bus(1'b0, tcu_pkg::addr_flags, 32'h0);
		`CHK("filtered", 1'b1, r[3])
		cap <= 1'b0;
		bus(1'b1, tcu_pkg::addr_control_a, 32'h1e);
		bus(1'b1, tcu_pkg::addr_flags, 32'h8);
		cap <= 1'b1;
		wt(20);
		bus(1'b0, tcu_pkg::addr_flags, 32'h0);
		`CHK("pin ignored", 1'b0, r[3])
		cmp <= 1'b1;
		wt(20);
		bus(1'b0, tcu_pkg::addr_flags, 32'h0);
		`CHK("comparator", 1'b1, r[3])
		finish_test;
	end
endmodule // tb
bind timer_capture_compare_unit tcu_checker chk (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .capture_pin(capture_pin), .comparator_output(comparator_output),
	.overflow_irq(overflow_irq), .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq),
	.capture_irq(capture_irq));
`default_nettype wire
